// file: verilog/ndi_pkg.sv
// Constants shared by the DMA interrupt logic and its receive coalescer.
// Assumes a single 125 MHz clock and 32-bit APB register access.
package ndi_pkg;

    // ---------------------------------------------------------------
    // Register byte offsets
    // ---------------------------------------------------------------
    localparam logic [11:0] REG_IRQ_STATUS = 12'h000;
    localparam logic [11:0] REG_IRQ_ENABLE = 12'h004;
    localparam logic [11:0] REG_TX_STATUS = 12'h008;
    localparam logic [11:0] REG_TX_CONTROL = 12'h00C;
    localparam logic [11:0] REG_RX_IRQ_CONTROL = 12'h010;
    localparam logic [11:0] REG_COAL_WAIT = 12'h014;
    localparam logic [11:0] REG_COAL_COUNT = 12'h018;

    // ---------------------------------------------------------------
    // Interrupt cause bit positions
    // ---------------------------------------------------------------
    localparam int NUM_IRQ = 5;
    localparam int IRQ_FETCH_DONE = 0;
    localparam int IRQ_TX_SENT = 1;
    localparam int IRQ_RX_DELIVERY = 2;
    localparam int IRQ_RX_PRIORITY = 3;
    localparam int IRQ_RX_LIST_END = 4;

    // ---------------------------------------------------------------
    // Transmit status and control fields
    // ---------------------------------------------------------------
    localparam int TXS_UNDERRUN = 0;
    localparam int TXS_MAC_EN = 1;
    localparam int TXS_DMA_RUN = 2;
    localparam int TXS_TAG_LSB = 8;
    localparam int TAG_W = 8;
    localparam int TXC_MAC_EN = 0;
    localparam int TXC_DMA_RST = 1;
    localparam int TXC_FIFO_RST = 2;
    localparam int TXC_MAC_RST = 3;

    // ---------------------------------------------------------------
    // Receive interrupt control fields
    // ---------------------------------------------------------------
    localparam int PRIO_W = 3;
    localparam int RXC_PRIO_LSB = 0;
    localparam int RXC_COUNT_LSB = 8;
    localparam int CNT_W = 8;
    localparam int WAIT_W = 16;
    localparam int DESC_PTR_W = 40;

    // ---------------------------------------------------------------
    // Reset values
    // ---------------------------------------------------------------
    localparam logic [NUM_IRQ-1:0] RST_IRQ_ENABLE = 5'h00;
    localparam logic [PRIO_W-1:0] RST_PRIO_THRESH = 3'h7;
    localparam logic [CNT_W-1:0] RST_COAL_COUNT = 8'h01;
    localparam logic [WAIT_W-1:0] RST_COAL_WAIT = 16'h0000;

    // ---------------------------------------------------------------
    // Timing: coalescing wait is counted in microseconds
    // ---------------------------------------------------------------
    localparam int CLK_PERIOD_PS = 8000;
    localparam int WAIT_UNIT_PS = 1000000;
    localparam int TICK_CYCLES = (WAIT_UNIT_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int TICK_W = 7;

endpackage

// file: verilog/ndi_coal_if.sv
// Carrier between the interrupt top and the receive coalescer.
// Assumes both ends share pclk; clock and reset travel as plain ports.
`timescale 1ns/100ps
`default_nettype none
interface ndi_coal_if;
    import ndi_pkg::*;
    logic ce;
    logic frame_evt;
    logic [CNT_W-1:0] target;
    logic [WAIT_W-1:0] wait_us;
    logic fire;
    logic [CNT_W-1:0] pend_count;

    modport top (
        output ce,
        output frame_evt,
        output target,
        output wait_us,
        input fire,
        input pend_count
    );
    modport coal (
        input ce,
        input frame_evt,
        input target,
        input wait_us,
        output fire,
        output pend_count
    );
endinterface
`default_nettype wire

// file: verilog/ndi_rx_coalesce.sv
// Receive delivery coalescer: counts frames, fires on count or timeout.
// Assumes frame_evt is a one-cycle pulse from logic on pclk.
`timescale 1ns/100ps
`default_nettype none
module ndi_rx_coalesce
    import ndi_pkg::*;
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Coalescer link
    ndi_coal_if.coal cif
);

    typedef enum logic [1:0] {
        NDI_CO_IDLE = 2'b01,
        NDI_CO_COLLECT = 2'b10
    } ndi_coal_e;

    ndi_coal_e state;
    ndi_coal_e next_state;
    logic [CNT_W-1:0] count;
    logic [CNT_W-1:0] next_count;
    logic [TICK_W-1:0] tick_cnt;
    logic [WAIT_W-1:0] us_cnt;
    logic fire;
    logic next_fire;

    // A target of zero behaves as one so frames are never held forever
    wire [CNT_W-1:0] eff_target = (cif.target == '0) ? 8'h01 : cif.target;
    wire [CNT_W-1:0] count_inc = count + 8'h01;
    wire tick = (tick_cnt == TICK_W'(TICK_CYCLES - 1));
    wire timed_out = (cif.wait_us != '0) && (us_cnt >= cif.wait_us);
    wire reach = cif.frame_evt && (count_inc >= eff_target);

    always_comb
    begin
        next_state = state;
        next_count = count;
        next_fire = 1'b0;
        case (state)
            NDI_CO_IDLE:
            begin
                if (reach)
                begin
                    next_fire = 1'b1;
                end
                else if (cif.frame_evt)
                begin
                    next_count = count_inc;
                    next_state = NDI_CO_COLLECT;
                end
            end
            NDI_CO_COLLECT:
            begin
                if (reach || timed_out)
                begin
                    next_fire = 1'b1;
                    next_count = '0;
                    next_state = NDI_CO_IDLE;
                end
                else if (cif.frame_evt)
                begin
                    next_count = count_inc;
                end
            end
            default:
            begin
                next_count = '0;
                next_state = NDI_CO_IDLE;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state <= NDI_CO_IDLE;
            count <= '0;
            fire <= 1'b0;
        end
        else if (cif.ce)
        begin
            state <= next_state;
            count <= next_count;
            fire <= next_fire;
        end
    end

    // Wait timer restarts with the first frame of a new batch, which moves the coalescer into collect
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            tick_cnt <= '0;
            us_cnt <= '0;
        end
        else if (cif.ce)
        begin
            if (state != NDI_CO_COLLECT)
            begin
                tick_cnt <= '0;
                us_cnt <= '0;
            end
            else if (tick)
            begin
                tick_cnt <= '0;
                us_cnt <= us_cnt + 16'h0001;
            end
            else
            begin
                tick_cnt <= tick_cnt + 7'h01;
            end
        end
    end

    assign cif.fire = fire;
    assign cif.pend_count = count;

endmodule // ndi_rx_coalesce
`default_nettype wire

// file: verilog/nic_dma_interrupt_logic.sv
// Transmit and receive DMA interrupt logic with APB register access.
// Assumes DMA event inputs are one-cycle pulses from logic on pclk,
// and that the interrupt pin is open-drain, resolved outside.
`timescale 1ns/100ps
`default_nettype none

module nic_dma_interrupt_logic
    import ndi_pkg::*;
(
    // Clock, reset, clock enable
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Transmit DMA and MAC events
    input wire logic tx_fetch_done_evt,
    input wire logic fetch_notify_bit,
    input wire logic tx_sent_evt,
    input wire logic send_notify_bit,
    input wire logic [TAG_W-1:0] tx_sent_tag,
    input wire logic tx_error_evt,
    input wire logic tx_underrun_evt,
    // Receive DMA events
    input wire logic rx_deliver_evt,
    input wire logic rx_deliver_prio_list,
    input wire logic rx_tag_valid,
    input wire logic [PRIO_W-1:0] rx_tag_priority,
    input wire logic rx_desc_valid,
    input wire logic [DESC_PTR_W-1:0] rx_next_desc_ptr,
    input wire logic rx_desc_done_bit,
    // Transmit function control
    output logic tx_mac_enable,
    output logic tx_dma_enable,
    output logic tx_dma_reset,
    output logic tx_fifo_reset,
    output logic tx_mac_reset,
    // Bus interrupt pin, open-drain
    output logic inta_out,
    output logic inta_oe_n
);

    // ---------------------------------------------------------------
    // APB decode
    // ---------------------------------------------------------------
    wire setup = psel && !penable;
    wire access = psel && penable && pready;
    wire wr = access && pwrite;
    // Full 12-bit match, so no register appears at an alias
    wire sel_status = (paddr == REG_IRQ_STATUS);
    wire sel_enable = (paddr == REG_IRQ_ENABLE);
    wire sel_txs = (paddr == REG_TX_STATUS);
    wire sel_txc = (paddr == REG_TX_CONTROL);
    wire sel_rxc = (paddr == REG_RX_IRQ_CONTROL);
    wire sel_wait = (paddr == REG_COAL_WAIT);
    wire sel_count = (paddr == REG_COAL_COUNT);
    wire mapped = sel_status || sel_enable || sel_txs || sel_txc
                  || sel_rxc || sel_wait || sel_count;
    wire wr_status = wr && sel_status;
    wire wr_enable = wr && sel_enable;
    wire wr_txc = wr && sel_txc;
    wire wr_rxc = wr && sel_rxc;
    wire wr_wait = wr && sel_wait;

    // ---------------------------------------------------------------
    // Register state
    // ---------------------------------------------------------------
    logic [NUM_IRQ-1:0] pending;
    logic [NUM_IRQ-1:0] irq_enable;
    logic underrun_flag;
    logic [TAG_W-1:0] last_sent_frame_tag;
    logic [PRIO_W-1:0] prio_thresh;
    logic [CNT_W-1:0] coal_target;
    logic [WAIT_W-1:0] coal_wait;
    logic [2:0] rst_owed;
    logic next_pready;

    ndi_coal_if cif();

    // ---------------------------------------------------------------
    // Event qualification
    // ---------------------------------------------------------------
    // An underrun is an error too: it reports and stops the MAC
    wire tx_err_any = tx_error_evt || tx_underrun_evt;
    // Fetch-done only for descriptors that ask for it
    wire ev_fetch = tx_fetch_done_evt && fetch_notify_bit;
    // Successful sends need the notify bit; errors always report
    wire ev_sent_ok = tx_sent_evt && send_notify_bit;
    wire ev_sent = ev_sent_ok || tx_err_any;
    wire ev_prio = rx_tag_valid && (rx_tag_priority >= prio_thresh);
    // Both list-end conditions report through one cause bit
    wire null_next = (rx_next_desc_ptr == 40'h00_0000_0000);
    wire ev_list_end = rx_desc_valid && (null_next || rx_desc_done_bit);
    // Priority lists report at once; nominal list goes to the coalescer
    wire ev_deliver_now = rx_deliver_evt && rx_deliver_prio_list;
    wire ev_deliver = ev_deliver_now || cif.fire;

    wire [NUM_IRQ-1:0] ev_set;
    assign ev_set[IRQ_FETCH_DONE] = ev_fetch;
    assign ev_set[IRQ_TX_SENT] = ev_sent;
    assign ev_set[IRQ_RX_DELIVERY] = ev_deliver;
    assign ev_set[IRQ_RX_PRIORITY] = ev_prio;
    assign ev_set[IRQ_RX_LIST_END] = ev_list_end;

    // ---------------------------------------------------------------
    // Coalescer hookup
    // ---------------------------------------------------------------
    // Only nominal-list frames are counted; the coalescer shares ce
    assign cif.ce = ce;
    assign cif.frame_evt = rx_deliver_evt && !rx_deliver_prio_list;
    assign cif.target = coal_target;
    assign cif.wait_us = coal_wait;

    ndi_rx_coalesce u_coal (
        .pclk(pclk),
        .presetn(presetn),
        .cif(cif)
    );

    // ---------------------------------------------------------------
    // Sticky interrupt causes
    // ---------------------------------------------------------------
    // A cause arriving during its own write-one-to-clear is kept
    genvar gi;
    generate
        for (gi = 0; gi < NUM_IRQ; gi++)
        begin : g_cause
            wire clr = wr_status && pwdata[gi];
            always_ff @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                    pending[gi] <= 1'b0;
                else if (ce)
                    pending[gi] <= ev_set[gi] || (pending[gi] && !clr);
            end
        end
    endgenerate

    // Enable masks only the pin; pending bits stay readable for polling
    wire irq_active = |(pending & irq_enable);

    // Pin is pulled low by enabling the zero driver
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            inta_out <= 1'b0;
            inta_oe_n <= 1'b1;
        end
        else if (ce)
        begin
            inta_out <= 1'b0;
            inta_oe_n <= !irq_active;
        end
    end

    // ---------------------------------------------------------------
    // Configuration registers
    // ---------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            irq_enable <= RST_IRQ_ENABLE;
        else if (ce && wr_enable)
            irq_enable <= pwdata[NUM_IRQ-1:0];
    end

    // Threshold and frame count share one word, so they move together
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prio_thresh <= RST_PRIO_THRESH;
            coal_target <= RST_COAL_COUNT;
        end
        else if (ce && wr_rxc)
        begin
            prio_thresh <= pwdata[RXC_PRIO_LSB +: PRIO_W];
            coal_target <= pwdata[RXC_COUNT_LSB +: CNT_W];
        end
    end

    // A changed wait applies to the batch already being collected
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            coal_wait <= RST_COAL_WAIT;
        else if (ce && wr_wait)
            coal_wait <= pwdata[WAIT_W-1:0];
    end

    // ---------------------------------------------------------------
    // Transmit status and function control
    // ---------------------------------------------------------------
    // Tag follows successful sends only, so polling software can free
    // every descriptor up to it without interrupts
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            last_sent_frame_tag <= '0;
        else if (ce && tx_sent_evt && !tx_err_any)
            last_sent_frame_tag <= tx_sent_tag;
    end

    // Underrun flag is cleared by writing one; a new underrun wins
    wire clr_underrun = wr && sel_txs && pwdata[TXS_UNDERRUN];
    wire wr_mac_en = wr_txc && pwdata[TXC_MAC_EN];
    wire [2:0] rst_req = wr_txc ? pwdata[TXC_MAC_RST:TXC_DMA_RST] : 3'h0;
    wire [2:0] next_rst_owed = tx_underrun_evt ? 3'h7 : (rst_owed & ~rst_req);

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            underrun_flag <= 1'b0;
        else if (ce)
            underrun_flag <= tx_underrun_evt || (underrun_flag && !clr_underrun);
    end

    // An error in the same cycle as the enable write wins
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            tx_mac_enable <= 1'b0;
        else if (ce && tx_err_any)
            tx_mac_enable <= 1'b0;
        else if (ce && wr_mac_en)
            tx_mac_enable <= 1'b1;
    end

    // DMA resumes only once all three functions have been reset;
    // a partial reset leaves it stopped, so any order is accepted
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            tx_dma_enable <= 1'b1;
            rst_owed <= 3'h0;
        end
        else if (ce)
        begin
            rst_owed <= next_rst_owed;
            tx_dma_enable <= (next_rst_owed == 3'h0);
        end
    end

    // Reset pulses last one enabled cycle
    // They fire on every request, owed or not, so software may repeat them
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            tx_dma_reset <= 1'b0;
            tx_fifo_reset <= 1'b0;
            tx_mac_reset <= 1'b0;
        end
        else if (ce)
        begin
            tx_dma_reset <= rst_req[0];
            tx_fifo_reset <= rst_req[1];
            tx_mac_reset <= rst_req[2];
        end
    end

    // ---------------------------------------------------------------
    // Read mux
    // ---------------------------------------------------------------
    wire [31:0] rd_status = {27'h000_0000, pending};
    wire [31:0] rd_enable = {27'h000_0000, irq_enable};
    wire [31:0] rd_txs = {16'h0000, last_sent_frame_tag, 5'h00,
                          tx_dma_enable, tx_mac_enable, underrun_flag};
    // Control reads back the enable and whether resets are still owed
    wire [31:0] rd_txc = {29'h0000_0000, rst_owed != 3'h0, 1'b0, tx_mac_enable};
    wire [31:0] rd_rxc = {16'h0000, coal_target, 5'h00, prio_thresh};
    wire [31:0] rd_wait = {16'h0000, coal_wait};
    wire [31:0] rd_count = {24'h00_0000, cif.pend_count};
    // Unmapped reads return zero together with pslverr
    wire [31:0] rd_data = sel_status ? rd_status :
                          sel_enable ? rd_enable :
                          sel_txs ? rd_txs :
                          sel_txc ? rd_txc :
                          sel_rxc ? rd_rxc :
                          sel_wait ? rd_wait :
                          sel_count ? rd_count : 32'h0000_0000;

    // ---------------------------------------------------------------
    // APB response: one wait state, answer registered
    // ---------------------------------------------------------------
    assign next_pready = psel && penable && !pready;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            pready <= 1'b0;
        else if (ce)
            pready <= next_pready;
    end

    // Data and error stand with pready only, then return to zero
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end
        else if (ce && next_pready)
        begin
            pslverr <= !mapped;
            prdata <= pwrite ? 32'h0000_0000 : rd_data;
        end
        else if (ce && (setup || access))
        begin
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end
    end

endmodule // nic_dma_interrupt_logic
`default_nettype wire

// file: verif/ndi_host_pin.sv
// Host side of the bus interrupt pin: open-drain line with a pull-up.
// Assumes the device sinks the line only while its enable is low.
`timescale 1ns/100ps
`default_nettype none
module ndi_host_pin (
    // Device pin
    input wire logic inta_out,
    input wire logic inta_oe_n,
    // Level seen by the host
    output logic intn
);
    // Pull-up: a released line reads high, never a stale level
    assign intn = inta_oe_n ? 1'b1 : inta_out;
endmodule // ndi_host_pin
`default_nettype wire

// file: verif/ndi_irq_properties.sv
// Port checks for the DMA interrupt block.
// Assumes one clock domain; bound to every instance of the top.
`timescale 1ns/100ps
`default_nettype none
module ndi_irq_properties (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    // APB
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic pready,
    input wire logic pslverr,
    // Transmit
    input wire logic tx_error_evt,
    input wire logic tx_underrun_evt,
    input wire logic tx_mac_enable,
    input wire logic tx_dma_enable,
    input wire logic tx_dma_reset,
    // Interrupt pin
    input wire logic inta_out,
    input wire logic inta_oe_n
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire wr_done = psel && penable && pwrite && pready;
    sequence apb_setup;
        ce && psel && !penable;
    endsequence
    sequence one_wait;
        !pready ##1 pready;
    endsequence
    AST_APB_WAIT: assert property (apb_setup |=> one_wait)
        else $error("pready not after one wait");
    AST_PREADY_PULSE: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    AST_SLVERR: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    AST_MAC_OFF: assert property (ce && (tx_error_evt || tx_underrun_evt) |=> !tx_mac_enable)
        else $error("mac still enabled after error");
    AST_DMA_STOP: assert property (ce && tx_underrun_evt |=> !tx_dma_enable)
        else $error("dma running after underrun");
    AST_DMA_KEEP: assert property (ce && tx_error_evt && !tx_underrun_evt && tx_dma_enable && !$past(tx_underrun_evt) |=> tx_dma_enable)
        else $error("dma stopped by plain error");
    AST_DMA_BACK: assert property ($rose(tx_dma_enable) |-> $past(wr_done))
        else $error("dma resumed without host write");
    AST_RST_PULSE: assert property (tx_dma_reset |=> !tx_dma_reset)
        else $error("dma reset pulse too long");
    AST_PIN_RELEASE: assert property ($rose(inta_oe_n) || inta_out |-> $past(wr_done, 2) && !inta_out)
        else $error("pin released without host write");
endmodule // ndi_irq_properties
bind nic_dma_interrupt_logic ndi_irq_properties prop_u (
    .pclk, .presetn, .ce, .psel, .penable, .pwrite, .pready, .pslverr,
    .tx_error_evt, .tx_underrun_evt, .tx_mac_enable, .tx_dma_enable,
    .tx_dma_reset, .inta_out, .inta_oe_n
);
`default_nettype wire

// file: verif/ndi_tb.sv
// Self-checking bench for the DMA interrupt block.
// Assumes the checker is bound in; clock enable drops once, for a freeze check.
`timescale 1ns/100ps
`default_nettype none
module tb;
    import ndi_pkg::*;
    logic pclk, presetn, ce, psel, penable, pwrite, pready, pslverr, er;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [6:0] evt;
    logic [2:0] trst;
    logic fetch_notify_bit, send_notify_bit, prio_list, done_bit;
    logic [TAG_W-1:0] tag;
    logic [PRIO_W-1:0] prio;
    logic [DESC_PTR_W-1:0] nptr;
    logic tx_mac_enable, tx_dma_enable, inta_out, inta_oe_n, intn;
    int err_total, checked;
    nic_dma_interrupt_logic dut_u (
        .pclk, .presetn, .ce, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .tx_fetch_done_evt(evt[0]), .fetch_notify_bit,
        .tx_sent_evt(evt[1]), .send_notify_bit, .tx_sent_tag(tag),
        .tx_error_evt(evt[2]), .tx_underrun_evt(evt[3]), .rx_deliver_evt(evt[4]),
        .rx_deliver_prio_list(prio_list), .rx_tag_valid(evt[5]), .rx_tag_priority(prio),
        .rx_desc_valid(evt[6]), .rx_next_desc_ptr(nptr), .rx_desc_done_bit(done_bit),
        .tx_mac_enable, .tx_dma_enable, .tx_dma_reset(trst[0]), .tx_fifo_reset(trst[1]),
        .tx_mac_reset(trst[2]), .inta_out, .inta_oe_n
    );
    ndi_host_pin host_u (.inta_out, .inta_oe_n, .intn);
    // ----
    // Bus, events and compare
    // ----
    task chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
        checked++;
        if (got !== ex)
        begin
            err_total++;
            $display("BAD %s expected %h seen %h", nm, ex, got);
        end
    endtask
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        {psel, penable} <= 2'b00;
    endtask
    task rdc(input logic [11:0] a, input logic [31:0] ex);
        apb(1'b0, a, 32'h0);
        chk("reg", ex, rd);
    endtask
    // Read causes, then clear all so each scenario starts clean
    task st(input logic [31:0] ex);
        rdc(REG_IRQ_STATUS, ex);
        apb(1'b1, REG_IRQ_STATUS, 32'h1F);
    endtask
    task fire(input int k);
        @(posedge pclk);
        evt <= 7'h01 << k;
        @(posedge pclk);
        evt <= 7'h00;
    endtask
    task t_reset;
        rdc(REG_IRQ_ENABLE, 32'h0);
        rdc(REG_RX_IRQ_CONTROL, 32'h0107);
        rdc(REG_TX_STATUS, 32'h0004);
        apb(1'b0, 12'h01C, 32'h0);
        chk("err", 32'h1, {31'h0, er});
    endtask
    task t_tx;
        apb(1'b1, REG_IRQ_ENABLE, 32'h1F);
        fire(0);
        fire(1);
        st(32'h0);
        fetch_notify_bit <= 1'b1;
        fire(0);
        repeat (2) @(posedge pclk);
        chk("intn", 32'h0, {31'h0, intn});
        st(32'h1);
        repeat (3) @(posedge pclk);
        chk("intn", 32'h1, {31'h0, intn});
        tag <= 8'hA5;
        send_notify_bit <= 1'b1;
        fire(1);
        st(32'h2);
        rdc(REG_TX_STATUS, 32'hA504);
    endtask
    task t_error;
        apb(1'b1, REG_TX_CONTROL, 32'h1);
        @(posedge pclk);
        chk("mac", 32'h1, {31'h0, tx_mac_enable});
        send_notify_bit <= 1'b0;
        fire(2);
        st(32'h2);
        chk("mac", 32'h0, {31'h0, tx_mac_enable});
        chk("dma", 32'h1, {31'h0, tx_dma_enable});
        apb(1'b1, REG_TX_CONTROL, 32'h1);
        fire(3);
        st(32'h2);
        rdc(REG_TX_STATUS, 32'hA501);
        apb(1'b1, REG_TX_CONTROL, 32'h6);
        rdc(REG_TX_CONTROL, 32'h4);
        rdc(REG_TX_STATUS, 32'hA501);
        apb(1'b1, REG_TX_CONTROL, 32'hE);
        @(posedge pclk);
        chk("rst", 32'h7, {29'h0, trst});
        apb(1'b1, REG_TX_STATUS, 32'h1);
        rdc(REG_TX_STATUS, 32'hA504);
    endtask
    task t_rx_events;
        apb(1'b1, REG_RX_IRQ_CONTROL, 32'h0104);
        prio <= 3'h3;
        nptr <= 40'h00_0000_0040;
        fire(5);
        fire(6);
        st(32'h0);
        prio <= 3'h4;
        ce <= 1'b0;
        fire(5);
        ce <= 1'b1;
        st(32'h0);
        fire(5);
        st(32'h8);
        nptr <= '0;
        fire(6);
        st(32'h10);
        nptr <= 40'h00_0000_0040;
        done_bit <= 1'b1;
        fire(6);
        st(32'h10);
    endtask
    task t_coal;
        apb(1'b1, REG_RX_IRQ_CONTROL, 32'h0304);
        fire(4);
        fire(4);
        rdc(REG_COAL_COUNT, 32'h2);
        st(32'h0);
        fire(4);
        st(32'h4);
        prio_list <= 1'b1;
        fire(4);
        st(32'h4);
        prio_list <= 1'b0;
        apb(1'b1, REG_COAL_WAIT, 32'h1);
        fire(4);
        repeat (100) @(posedge pclk);
        st(32'h0);
        repeat (40) @(posedge pclk);
        st(32'h4);
    endtask
    task finish_test;
        if (err_total == 0 && checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    initial
    begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end
    // Whole run is about 400 cycles; the limit leaves wide margin
    initial
    begin
        #(8 * 20000);
        err_total++;
        finish_test;
    end
    initial
    begin
        err_total = 0;
        checked = 0;
        presetn = 1'b0;
        ce = 1'b1;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        {evt, fetch_notify_bit, send_notify_bit, prio_list, done_bit, tag, prio, nptr} = '0;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        t_reset;
        t_tx;
        t_error;
        t_rx_events;
        t_coal;
        finish_test;
    end
endmodule // tb
`default_nettype wire
